//--- rtl/spbt_defines.svh
`ifndef SPBT_DEFINES_SVH
`define SPBT_DEFINES_SVH

// Telegram identifiers and selector codes.
`define SPBT_REQ_ID 11'h44D
`define SPBT_RPL_ID 11'h529
`define SPBT_SEL_READ 8'h0B
`define SPBT_SEL_WRITE 8'h08

// Status byte bits, bit 0 is set only by the list end marker 8'hFF.
`define SPBT_ST_OK 8'h00
`define SPBT_ST_WATCHDOG 8'h02
`define SPBT_ST_MODE 8'h04
`define SPBT_ST_NO_READ 8'h08
`define SPBT_ST_REPEAT 8'h10
`define SPBT_ST_UNKNOWN 8'h20
`define SPBT_ST_NO_CHANGE 8'h40
`define SPBT_ST_BAD_VALUE 8'h80
`define SPBT_LIST_END 8'hFF

// String limits.
`define SPBT_MAX_CHARS 9'd100
`define SPBT_MAX_RLEN 7'd100
`define SPBT_BUF_WORDS 26

// Register offsets and fields.
`define SPBT_OFS_CTRL 12'h000
`define SPBT_OFS_STAT 12'h004
`define SPBT_OFS_RLEN 12'h008
`define SPBT_OFS_WLEN 12'h00C
`define SPBT_PAGE_RBUF 4'h1
`define SPBT_PAGE_WBUF 4'h2
`define SPBT_CTRL_RST 32'h0000_0000
`define SPBT_CTRL_RD_BIT 0
`define SPBT_CTRL_WR_BIT 1
`define SPBT_STAT_NEW_BIT 8

`endif

//--- rtl/spbt_pkg.sv
package spbt_pkg;

   typedef enum logic [1:0] {ST_IDLE, ST_READ, ST_WRITE} xfer_state_e;

endpackage : spbt_pkg

//--- rtl/string_param_block_transfer.sv
`timescale 1ns/1ns
`include "spbt_defines.svh"

// Pointers wrap by plain increment, so DEPTH must be a power of two.
module telegram_fifo #(
   parameter int WIDTH = 75,
   parameter int DEPTH = 4
) (
   // Clock and reset.
   input wire logic core_clk_i,
   input wire logic rst_i,
   // Filling side.
   input wire logic in_valid_i,
   output logic in_ready_o,
   input wire logic [WIDTH-1:0] in_data_i,
   // Draining side.
   output logic out_valid_o,
   input wire logic out_ready_i,
   output logic [WIDTH-1:0] out_data_o
);
   localparam int AW = $clog2(DEPTH);
   logic [WIDTH-1:0] mem_reg [DEPTH];
   logic [AW-1:0] wr_ptr_reg;
   logic [AW-1:0] rd_ptr_reg;
   logic [AW:0] count_reg;
   logic [AW:0] count_next;
   logic ready_reg;
   wire push = in_valid_i && ready_reg;
   wire pop = out_valid_o && out_ready_i;
   assign in_ready_o = ready_reg;
   assign out_valid_o = count_reg != '0;
   assign out_data_o = mem_reg[rd_ptr_reg];
   assign count_next = count_reg + (AW+1)'(push) - (AW+1)'(pop);

   always_ff @(posedge core_clk_i or posedge rst_i) begin
      if (rst_i) begin
         wr_ptr_reg <= '0;
         rd_ptr_reg <= '0;
         count_reg <= '0;
         ready_reg <= 1'b0;
      end else begin
         wr_ptr_reg <= wr_ptr_reg + AW'(push);
         rd_ptr_reg <= rd_ptr_reg + AW'(pop);
         count_reg <= count_next;
         ready_reg <= count_next != (AW+1)'(DEPTH);
      end
   end

   always_ff @(posedge core_clk_i) begin
      if (push) begin
         mem_reg[wr_ptr_reg] <= in_data_i;
      end
   end
endmodule : telegram_fifo

////////////////////////////////////////////////////////////////////////////
module string_param_block_transfer #(
   parameter int FIFO_DEPTH = 4
) (
   // Clock and reset.
   input wire logic core_clk_i,
   input wire logic rst_i,
   // APB slave.
   input wire logic psel_i,
   input wire logic penable_i,
   input wire logic pwrite_i,
   input wire logic [11:0] paddr_i,
   input wire logic [31:0] pwdata_i,
   output logic [31:0] prdata_o,
   output logic pready_o,
   output logic pslverr_o,
   // Received telegrams.
   input wire logic rx_valid_i,
   output logic rx_ready_o,
   input wire logic [10:0] rx_id_i,
   input wire logic [63:0] rx_data_i,
   // Reply telegrams.
   output logic tx_valid_o,
   input wire logic tx_ready_i,
   output logic [10:0] tx_id_o,
   output logic [63:0] tx_data_o
);
   function automatic logic [7:0] access_status(input logic known,
         input logic permit, input logic [7:0] deny);
      access_status = !known ? `SPBT_ST_UNKNOWN :
         (permit ? `SPBT_ST_OK : deny);
   endfunction : access_status

   function automatic logic [2:0] term_pos(input logic [31:0] w);
      logic [2:0] pos;
      pos = 3'd4;
      for (int i = 3; i >= 0; i--) begin
         if (w[8*i +: 8] == 8'h00) begin
            pos = 3'(i);
         end
      end
      return pos;
   endfunction : term_pos

   spbt_pkg::xfer_state_e state_reg, state_next;
   logic [7:0] expect_reg, expect_next, reply_status, deny_chk;
   logic [31:0] csum_reg, csum_next, reply_word, ctrl_reg;
   logic [8:0] wchars_reg, wchars_next;
   logic term_reg, term_next, ovf_reg, ovf_next, send, commit, wbuf_we;
   logic [6:0] rlen_reg, wlen_reg;
   logic new_reg;
   logic [7:0] last_status_reg;
   logic [31:0] rbuf_reg [`SPBT_BUF_WORDS];
   logic [31:0] wbuf_reg [`SPBT_BUF_WORDS];
   logic tx_valid_reg, pready_reg, pslverr_reg;
   logic [63:0] tx_data_reg;
   logic [10:0] tx_id_reg;
   logic [31:0] prdata_reg;
   logic [74:0] q;
   logic q_valid;

   ////////////////////////////////////////////////////////////////////////
   // Telegrams wait here while a reply is still pending on the bus.
   telegram_fifo #(.WIDTH(75), .DEPTH(FIFO_DEPTH)) u_rx_fifo (
      .core_clk_i(core_clk_i),
      .rst_i(rst_i),
      .in_valid_i(rx_valid_i),
      .in_ready_o(rx_ready_o),
      .in_data_i({rx_id_i, rx_data_i}),
      .out_valid_o(q_valid),
      .out_ready_i(!tx_valid_reg),
      .out_data_o(q)
   );

   wire take = q_valid && !tx_valid_reg;
   wire is_req = take && q[74:64] == `SPBT_REQ_ID;
   wire [7:0] q_sel = q[23:16];
   wire [31:0] q_word = q[55:24];
   wire [7:0] q_cnt = q[63:56];
   wire known = q[15:0] == ctrl_reg[31:16];
   wire rd_ok = ctrl_reg[`SPBT_CTRL_RD_BIT];
   wire wr_ok = ctrl_reg[`SPBT_CTRL_WR_BIT];
   wire [7:0] rlast = {3'b000, rlen_reg[6:2]};
   wire [31:0] rword = (q_cnt < 8'(`SPBT_BUF_WORDS)) ?
      rbuf_reg[q_cnt[4:0]] : 32'h0000_0000;
   wire [7:0] widx = q_cnt - 8'h01;
   wire [2:0] pos = term_pos(q_word);
   wire [8:0] wsum = wchars_reg + 9'(pos);
   wire rd_step = is_req && q_cnt != 8'h00 && q_cnt == expect_reg &&
      state_reg == spbt_pkg::ST_READ && q_sel == `SPBT_SEL_READ;
   wire wr_step = is_req && q_cnt != 8'h00 && q_cnt == expect_reg &&
      state_reg == spbt_pkg::ST_WRITE && q_sel == `SPBT_SEL_WRITE;
   wire rd_final = rd_step && q_cnt > rlast;
   wire wr_final = wr_step && term_reg;

   ////////////////////////////////////////////////////////////////////////
   // Sequencer. A counter of 0 always restarts, so a master that lost
   // track recovers without waiting for a timeout.
   always_comb begin
      state_next = state_reg;
      expect_next = expect_reg;
      csum_next = csum_reg;
      wchars_next = wchars_reg;
      term_next = term_reg;
      ovf_next = ovf_reg;
      send = 1'b0;
      commit = 1'b0;
      wbuf_we = 1'b0;
      reply_status = `SPBT_ST_OK;
      reply_word = q_word;
      deny_chk = access_status(known, wr_ok, `SPBT_ST_NO_CHANGE);
      if (is_req && q_cnt == 8'h00) begin
         send = 1'b1;
         expect_next = 8'h01;
         csum_next = 32'h0000_0000;
         wchars_next = 9'h000;
         term_next = 1'b0;
         ovf_next = 1'b0;
         state_next = spbt_pkg::ST_IDLE;
         if (q_sel == `SPBT_SEL_READ) begin
            reply_status = access_status(known, rd_ok, `SPBT_ST_NO_READ);
            reply_word = rword;
            csum_next = rword;
            if (reply_status == `SPBT_ST_OK) begin
               state_next = spbt_pkg::ST_READ;
            end
         end else if (q_sel == `SPBT_SEL_WRITE) begin
            reply_status = deny_chk;
            if (reply_status == `SPBT_ST_OK) begin
               state_next = spbt_pkg::ST_WRITE;
            end
         end else begin
            reply_status = `SPBT_ST_MODE;
         end
      end else if (rd_final) begin
         send = 1'b1;
         reply_status = `SPBT_LIST_END;
         reply_word = csum_reg;
         state_next = spbt_pkg::ST_IDLE;
      end else if (rd_step) begin
         send = 1'b1;
         reply_word = rword;
         csum_next = csum_reg ^ rword;
         expect_next = expect_reg + 8'h01;
         if (q_cnt == 8'h01) begin
            reply_status = access_status(known, rd_ok, `SPBT_ST_NO_READ);
         end
         if (reply_status != `SPBT_ST_OK) begin
            state_next = spbt_pkg::ST_IDLE;
         end
      end else if (wr_final) begin
         send = 1'b1;
         reply_status = (ovf_reg ? `SPBT_ST_BAD_VALUE : `SPBT_ST_OK) |
            ((q_word != csum_reg) ? `SPBT_ST_REPEAT : `SPBT_ST_OK);
         commit = reply_status == `SPBT_ST_OK;
         state_next = spbt_pkg::ST_IDLE;
      end else if (wr_step) begin
         send = 1'b1;
         expect_next = expect_reg + 8'h01;
         csum_next = csum_reg ^ q_word;
         wbuf_we = widx < 8'(`SPBT_BUF_WORDS);
         term_next = pos != 3'd4;
         if (wsum > `SPBT_MAX_CHARS) begin
            ovf_next = 1'b1;
         end else begin
            wchars_next = wsum;
         end
         if (q_cnt == 8'h01) begin
            reply_status = deny_chk;
         end
         if (reply_status != `SPBT_ST_OK) begin
            state_next = spbt_pkg::ST_IDLE;
         end
      end else if (is_req) begin
         state_next = spbt_pkg::ST_IDLE;
      end
   end

   always_ff @(posedge core_clk_i or posedge rst_i) begin
      if (rst_i) begin
         state_reg <= spbt_pkg::ST_IDLE;
         expect_reg <= 8'h00;
         csum_reg <= 32'h0000_0000;
         wchars_reg <= 9'h000;
         term_reg <= 1'b0;
         ovf_reg <= 1'b0;
         tx_valid_reg <= 1'b0;
         tx_id_reg <= 11'h000;
         tx_data_reg <= 64'h0;
         last_status_reg <= 8'h00;
      end else begin
         state_reg <= state_next;
         expect_reg <= expect_next;
         csum_reg <= csum_next;
         wchars_reg <= wchars_next;
         term_reg <= term_next;
         ovf_reg <= ovf_next;
         tx_valid_reg <= send || (tx_valid_reg && !tx_ready_i);
         if (send) begin
            tx_id_reg <= `SPBT_RPL_ID;
            tx_data_reg <= {q_cnt, reply_word, reply_status, q[15:0]};
            last_status_reg <= reply_status;
         end
      end
   end

   always_ff @(posedge core_clk_i) begin
      if (wbuf_we) begin
         wbuf_reg[widx[4:0]] <= q_word;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // APB slave with one wait state, so read data is always a flop output.
   wire apb_req = psel_i && penable_i && !pready_reg;
   wire apb_wr = psel_i && penable_i && pready_reg && pwrite_i;
   wire [5:0] aidx = paddr_i[7:2];
   wire in_buf = aidx < 6'(`SPBT_BUF_WORDS) && paddr_i[1:0] == 2'b00;
   wire hit_rbuf = paddr_i[11:8] == `SPBT_PAGE_RBUF && in_buf;
   wire hit_wbuf = paddr_i[11:8] == `SPBT_PAGE_WBUF && in_buf;
   wire hit_ctrl = paddr_i == `SPBT_OFS_CTRL;
   wire hit_stat = paddr_i == `SPBT_OFS_STAT;
   wire hit_rlen = paddr_i == `SPBT_OFS_RLEN;
   wire hit_wlen = paddr_i == `SPBT_OFS_WLEN;
   wire hit = hit_rbuf || hit_wbuf || hit_ctrl || hit_stat || hit_rlen ||
      hit_wlen;
   wire [31:0] stat_word = {8'h00, last_status_reg, 7'h00, new_reg, 6'h00,
      state_reg};
   wire [31:0] rd_mux = hit_ctrl ? ctrl_reg : hit_stat ? stat_word :
      hit_rlen ? {25'h0, rlen_reg} : hit_wlen ? {25'h0, wlen_reg} :
      hit_rbuf ? rbuf_reg[aidx[4:0]] : hit_wbuf ? wbuf_reg[aidx[4:0]] :
      32'h0000_0000;
   wire clr_new = apb_wr && hit_stat && pwdata_i[`SPBT_STAT_NEW_BIT];
   // The whole word is compared, so large values clamp instead of wrapping.
   wire [6:0] rlen_wr = (pwdata_i > 32'(`SPBT_MAX_RLEN)) ?
      `SPBT_MAX_RLEN : pwdata_i[6:0];

   always_ff @(posedge core_clk_i or posedge rst_i) begin
      if (rst_i) begin
         pready_reg <= 1'b0;
         pslverr_reg <= 1'b0;
         prdata_reg <= 32'h0000_0000;
         ctrl_reg <= `SPBT_CTRL_RST;
         rlen_reg <= 7'h00;
         wlen_reg <= 7'h00;
         new_reg <= 1'b0;
      end else begin
         pready_reg <= apb_req;
         pslverr_reg <= apb_req && !hit;
         prdata_reg <= apb_req ? rd_mux : 32'h0000_0000;
         ctrl_reg <= (apb_wr && hit_ctrl) ? pwdata_i : ctrl_reg;
         rlen_reg <= (apb_wr && hit_rlen) ? rlen_wr : rlen_reg;
         wlen_reg <= commit ? wchars_reg[6:0] : wlen_reg;
         // A commit in the clearing cycle keeps the flag set.
         new_reg <= commit || (new_reg && !clr_new);
      end
   end

   always_ff @(posedge core_clk_i) begin
      if (apb_wr && hit_rbuf) begin
         rbuf_reg[aidx[4:0]] <= pwdata_i;
      end
   end

   assign prdata_o = prdata_reg;
   assign pready_o = pready_reg;
   assign pslverr_o = pslverr_reg;
   assign tx_valid_o = tx_valid_reg;
   assign tx_id_o = tx_id_reg;
   assign tx_data_o = tx_data_reg;

   ////////////////////////////////////////////////////////////////////////
   sequence s_final_write;
      wr_final;
   endsequence
   sequence s_reply_out(logic [7:0] st);
      tx_valid_o && tx_data_o[23:16] == st;
   endsequence

   property p_reply_id;
      @(posedge core_clk_i) disable iff (rst_i)
      tx_valid_o |-> tx_id_o == `SPBT_RPL_ID;
   endproperty
   a_reply_id: assert property (p_reply_id)
      else $error("Reply not on answer identifier.");

   property p_copy;
      @(posedge core_clk_i) disable iff (rst_i)
      send |=> tx_data_o[63:56] == $past(q_cnt) &&
         tx_data_o[15:0] == $past(q[15:0]);
   endproperty
   a_copy: assert property (p_copy)
      else $error("Reply does not copy counter or parameter.");

   property p_bad_counter;
      @(posedge core_clk_i) disable iff (rst_i)
      is_req && q_cnt != 8'h00 && q_cnt != expect_reg |=>
         state_reg == spbt_pkg::ST_IDLE && !tx_valid_o;
   endproperty
   a_bad_counter: assert property (p_bad_counter)
      else $error("Bad counter did not reset the sequencer.");

   property p_error_ends;
      @(posedge core_clk_i) disable iff (rst_i)
      send && reply_status != `SPBT_ST_OK &&
         reply_status != `SPBT_LIST_END |=>
         state_reg == spbt_pkg::ST_IDLE [*2];
   endproperty
   a_error_ends: assert property (p_error_ends)
      else $error("Error status did not end the transfer.");

   property p_read_ok;
      @(posedge core_clk_i) disable iff (rst_i)
      is_req && q_cnt == 8'h00 && q_sel == `SPBT_SEL_READ && known &&
         rd_ok |=> s_reply_out(`SPBT_ST_OK) ##0
         state_reg == spbt_pkg::ST_READ;
   endproperty
   a_read_ok: assert property (p_read_ok)
      else $error("Permitted read start refused.");

   property p_echo;
      @(posedge core_clk_i) disable iff (rst_i)
      wr_step |=> tx_valid_o && tx_data_o[55:24] == $past(q_word);
   endproperty
   a_echo: assert property (p_echo)
      else $error("Write block not echoed.");

   property p_overflow;
      @(posedge core_clk_i) disable iff (rst_i)
      s_final_write ##0 ovf_reg |=> tx_data_o[23] && $stable(wlen_reg);
   endproperty
   a_overflow: assert property (p_overflow)
      else $error("Overlong string not flagged with bit 7.");

   property p_repeat;
      @(posedge core_clk_i) disable iff (rst_i)
      s_final_write ##0 q_word != csum_reg |=> tx_data_o[20] &&
         !$rose(new_reg) && $stable(wlen_reg);
   endproperty
   a_repeat: assert property (p_repeat)
      else $error("Checksum mismatch without repeat bit 4.");

   property p_list_end;
      @(posedge core_clk_i) disable iff (rst_i)
      rd_final |=> s_reply_out(`SPBT_LIST_END) ##0
         tx_data_o[55:24] == $past(csum_reg);
   endproperty
   a_list_end: assert property (p_list_end)
      else $error("Final read reply lacks marker or checksum.");
endmodule : string_param_block_transfer

//--- verif/can_master_model.sv
`timescale 1ns/1ns
`include "spbt_defines.svh"

// Stands in for the fieldbus master on the telegram side of the block.
module can_master_model (
   // Clock.
   input wire logic core_clk_i,
   // Request telegrams towards the drive.
   output logic rx_valid_o,
   input wire logic rx_ready_i,
   output logic [10:0] rx_id_o,
   output logic [63:0] rx_data_o,
   // Replies from the drive.
   input wire logic tx_valid_i,
   output logic tx_ready_o,
   input wire logic [10:0] tx_id_i,
   input wire logic [63:0] tx_data_i
);

   initial begin
      rx_valid_o = 1'b0;
      rx_id_o = 11'h000;
      rx_data_o = 64'h0;
      tx_ready_o = 1'b0;
   end

   ////////////////////////////////////////////////////////////////////////
   // Released lines show the inverse of the last value, so that the drive
   // can never pick up a stale telegram by accident.
   task automatic send(input logic [10:0] id, input logic [63:0] data);
      @(posedge core_clk_i);
      rx_valid_o <= 1'b1;
      rx_id_o <= id;
      rx_data_o <= data;
      do begin
         @(posedge core_clk_i);
      end while (rx_ready_i !== 1'b1);
      rx_valid_o <= 1'b0;
      rx_id_o <= ~id;
      rx_data_o <= ~data;
   endtask : send

   // A reply that never comes is left to the watchdog of the bench.
   task automatic recv(output logic [10:0] id, output logic [63:0] data);
      @(posedge core_clk_i);
      tx_ready_o <= 1'b1;
      do begin
         @(posedge core_clk_i);
      end while (tx_valid_i !== 1'b1);
      id = tx_id_i;
      data = tx_data_i;
      tx_ready_o <= 1'b0;
   endtask : recv

   task automatic request(input logic [7:0] sel, input logic [7:0] cnt,
                          input logic [31:0] word, input logic [15:0] par);
      send(`SPBT_REQ_ID, {cnt, word, sel, par});
   endtask : request

endmodule : can_master_model

//--- verif/test_string_param_block_transfer.sv
`timescale 1ns/1ns
`include "spbt_defines.svh"

module test_string_param_block_transfer;

   localparam logic [15:0] PAR = 16'h0123;
   localparam logic [31:0] R0 = 32'h44434241;
   localparam logic [31:0] R1 = 32'h00004645;
   localparam logic [31:0] W1 = 32'h5A595857;
   localparam logic [31:0] W2 = 32'h00003231;
   localparam logic [31:0] AS = 32'h41414141;

   logic core_clk, rst, psel, penable, pwrite, pready, pslverr;
   logic [11:0] paddr;
   logic [31:0] pwdata, prdata;
   logic rx_valid, rx_ready, tx_valid, tx_ready;
   logic [10:0] rx_id, tx_id;
   logic [63:0] rx_data, tx_data;
   logic [15:0] par;
   int failures, checks_done;

   string_param_block_transfer #(.FIFO_DEPTH(4)) i_string_param_block_transfer (
      .core_clk_i(core_clk), .rst_i(rst), .psel_i(psel), .penable_i(penable),
      .pwrite_i(pwrite), .paddr_i(paddr), .pwdata_i(pwdata),
      .prdata_o(prdata), .pready_o(pready), .pslverr_o(pslverr),
      .rx_valid_i(rx_valid), .rx_ready_o(rx_ready), .rx_id_i(rx_id),
      .rx_data_i(rx_data), .tx_valid_o(tx_valid), .tx_ready_i(tx_ready),
      .tx_id_o(tx_id), .tx_data_o(tx_data));

   can_master_model i_can_master_model (
      .core_clk_i(core_clk), .rx_valid_o(rx_valid), .rx_ready_i(rx_ready),
      .rx_id_o(rx_id), .rx_data_o(rx_data), .tx_valid_i(tx_valid),
      .tx_ready_o(tx_ready), .tx_id_i(tx_id), .tx_data_i(tx_data));

   always #20 core_clk = ~core_clk;

   ////////////////////////////////////////////////////////////////////////
   task automatic conclude;
      $display("checks %0d, failures %0d", checks_done, failures);
      if (failures == 0 && checks_done > 0)
         $display("STATUS OK");
      else
         $display("STATUS NOT OK");
      $finish;
   endtask : conclude

   task automatic check_word(input logic [31:0] got, input logic [31:0] exp);
      checks_done++;
      if (got !== exp) begin
         failures++;
         $display("wrong value at %0t: word %h, expected %h", $time, got, exp);
      end
   endtask : check_word

   task automatic check_reply(input logic [10:0] id, input logic [63:0] got,
                              input logic [63:0] exp);
      checks_done++;
      if (id !== `SPBT_RPL_ID || got !== exp) begin
         failures++;
         $display("wrong value at %0t: reply %h, expected %h", $time, got, exp);
      end
   endtask : check_reply

   task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d,
                      output logic [31:0] r, output logic e);
      @(posedge core_clk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge core_clk);
      penable <= 1'b1;
      do begin
         @(posedge core_clk);
      end while (pready !== 1'b1);
      r = prdata;
      e = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask : apb

   task automatic wr(input logic [11:0] a, input logic [31:0] d);
      logic [31:0] r;
      logic e;
      apb(1'b1, a, d, r, e);
   endtask : wr

   task automatic rd(input logic [11:0] a, input logic [31:0] exp);
      logic [31:0] r;
      logic e;
      apb(1'b0, a, 32'h0, r, e);
      check_word(r, exp);
      check_word({31'h0, e}, 32'h0);
   endtask : rd

   // Error replies leave the data bytes open, so care masks them out.
   task automatic ask(input logic [7:0] sel, input logic [7:0] cnt,
                      input logic [31:0] word, input logic [7:0] st,
                      input logic [31:0] expw, input logic care);
      logic [10:0] id;
      logic [63:0] got, m;
      m = care ? 64'hFFFF_FFFF_FFFF_FFFF : 64'hFF00_0000_00FF_FFFF;
      i_can_master_model.request(sel, cnt, word, par);
      i_can_master_model.recv(id, got);
      check_reply(id, got & m, {cnt, expw, st, par} & m);
   endtask : ask

   // No reply may appear while the far side would gladly wait for one.
   task automatic quiet;
      repeat (8) @(posedge core_clk);
      check_word({31'h0, tx_valid}, 32'h0);
   endtask : quiet

   ////////////////////////////////////////////////////////////////////////
   initial begin
      #400000;
      failures++;
      conclude();
   end

   initial begin
      logic [31:0] r;
      logic e;
      core_clk = 1'b0;
      rst = 1'b1;
      {psel, penable, pwrite} = 3'b000;
      paddr = 12'h000;
      pwdata = 32'h0;
      par = PAR;
      failures = 0;
      checks_done = 0;
      repeat (2) @(posedge core_clk);
      rst <= 1'b0;
      repeat (2) @(posedge core_clk);
      rd(`SPBT_OFS_CTRL, 32'h0);
      rd(`SPBT_OFS_STAT, 32'h0);
      rd(`SPBT_OFS_WLEN, 32'h0);
      wr(`SPBT_OFS_CTRL, {PAR, 16'h0003});
      wr(`SPBT_OFS_RLEN, 32'd200);
      rd(`SPBT_OFS_RLEN, 32'd100);
      wr(`SPBT_OFS_RLEN, 32'd6);
      wr(12'h100, R0);
      wr(12'h104, R1);
      rd(12'h104, R1);
      ask(`SPBT_SEL_READ, 8'h00, 32'h0, 8'h00, R0, 1'b1);
      ask(`SPBT_SEL_READ, 8'h01, 32'h0, 8'h00, R1, 1'b1);
      ask(`SPBT_SEL_READ, 8'h02, 32'h0, 8'hFF, R0 ^ R1, 1'b1);
      ask(`SPBT_SEL_READ, 8'h00, 32'h0, 8'h00, R0, 1'b1);
      i_can_master_model.request(`SPBT_SEL_READ, 8'h05, 32'h0, par);
      quiet();
      i_can_master_model.request(`SPBT_SEL_READ, 8'h01, 32'h0, par);
      quiet();
      i_can_master_model.send(11'h123, {8'h00, 32'h0, `SPBT_SEL_READ, par});
      quiet();
      ask(8'h05, 8'h00, 32'h0, `SPBT_ST_MODE, 32'h0, 1'b0);
      par = 16'h0099;
      ask(`SPBT_SEL_READ, 8'h00, 32'h0, `SPBT_ST_UNKNOWN, 32'h0, 1'b0);
      par = PAR;
      wr(`SPBT_OFS_CTRL, {PAR, 16'h0002});
      ask(`SPBT_SEL_READ, 8'h00, 32'h0, `SPBT_ST_NO_READ, 32'h0, 1'b0);
      wr(`SPBT_OFS_CTRL, {PAR, 16'h0003});
      ask(`SPBT_SEL_READ, 8'h00, 32'h0, 8'h00, R0, 1'b1);
      wr(`SPBT_OFS_CTRL, {PAR, 16'h0002});
      ask(`SPBT_SEL_READ, 8'h01, 32'h0, `SPBT_ST_NO_READ, 32'h0, 1'b0);
      i_can_master_model.request(`SPBT_SEL_READ, 8'h02, 32'h0, par);
      quiet();
      wr(`SPBT_OFS_CTRL, {PAR, 16'h0001});
      ask(`SPBT_SEL_WRITE, 8'h00, 32'h0, `SPBT_ST_NO_CHANGE, 32'h0, 1'b0);
      wr(`SPBT_OFS_CTRL, {PAR, 16'h0003});
      ask(`SPBT_SEL_WRITE, 8'h00, 32'hDEADBEEF, 8'h00, 32'h0, 1'b0);
      ask(`SPBT_SEL_WRITE, 8'h01, W1, 8'h00, W1, 1'b1);
      ask(`SPBT_SEL_WRITE, 8'h02, W2, 8'h00, W2, 1'b1);
      ask(`SPBT_SEL_WRITE, 8'h03, W1 ^ W2, 8'h00, 32'h0, 1'b0);
      rd(`SPBT_OFS_WLEN, 32'd6);
      rd(12'h200, W1);
      rd(12'h204, W2);
      rd(`SPBT_OFS_STAT, 32'h0000_0100);
      wr(`SPBT_OFS_STAT, 32'h0000_0100);
      rd(`SPBT_OFS_STAT, 32'h0);
      ask(`SPBT_SEL_WRITE, 8'h00, 32'h0, 8'h00, 32'h0, 1'b0);
      ask(`SPBT_SEL_WRITE, 8'h01, W1, 8'h00, W1, 1'b1);
      ask(`SPBT_SEL_WRITE, 8'h02, W2, 8'h00, W2, 1'b1);
      ask(`SPBT_SEL_WRITE, 8'h03, W1 ^ W2 ^ 32'h1, `SPBT_ST_REPEAT,
          32'h0, 1'b0);
      ask(`SPBT_SEL_WRITE, 8'h00, 32'h0, 8'h00, 32'h0, 1'b0);
      wr(`SPBT_OFS_CTRL, {PAR, 16'h0001});
      ask(`SPBT_SEL_WRITE, 8'h01, W1, `SPBT_ST_NO_CHANGE, 32'h0, 1'b0);
      wr(`SPBT_OFS_CTRL, {PAR, 16'h0003});
      // An even count of equal blocks cancels, so the checksum stays zero.
      ask(`SPBT_SEL_WRITE, 8'h00, 32'h0, 8'h00, 32'h0, 1'b0);
      for (int k = 1; k <= 27; k++)
         ask(`SPBT_SEL_WRITE, 8'(k), (k < 27) ? AS : 32'h0, 8'h00,
             (k < 27) ? AS : 32'h0, 1'b1);
      ask(`SPBT_SEL_WRITE, 8'd28, 32'h0, `SPBT_ST_BAD_VALUE,
          32'h0, 1'b0);
      repeat (5) i_can_master_model.request(`SPBT_SEL_READ, 8'h00, 32'h0, par);
      repeat (2) @(posedge core_clk);
      check_word({31'h0, rx_ready}, 32'h0);
      repeat (5) begin
         logic [10:0] id;
         logic [63:0] got;
         i_can_master_model.recv(id, got);
         check_reply(id, got, {8'h00, R0, 8'h00, par});
      end
      apb(1'b0, 12'h010, 32'h0, r, e);
      check_word(r, 32'h0);
      check_word({31'h0, e}, 32'h1);
      conclude();
   end

endmodule : test_string_param_block_transfer
